// file: testbench/crf_core_regs_assertions.sv
// concurrent checks on the register file ports
`timescale 1ns/10ps
module crf_core_regs_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input crf_pkg::crf_wr_t ex_wr,
  input crf_pkg::crf_alu_t alu,
  input wire logic pc_step_en,
  input wire logic [2:0] pc_step_len,
  input wire logic [10:0] cpu_flags,
  input wire logic [19:0] next_instr_ptr
);
  // ==========
  // apb handshake
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_take;
    psel && penable && !pready && !ex_wr.en;
  endsequence
  // program counter load this cycle, from either writer
  logic pc_load;
  assign pc_load = (ex_wr.en && ex_wr.id == crf_pkg::ID_NEXT_INSTR) ||
                   (psel && penable && !pready && !ex_wr.en && pwrite && paddr == 12'h04C);
  property p_take_ready;
    s_take |=> pready;
  endproperty
  a_take_ready: assert property (p_take_ready) else $error("no answer after access");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than a cycle");
  property p_err_ready;
    pslverr |-> pready && prdata == 32'h00000000;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without pready");
  // ==========
  // flags and program counter
  property p_carry;
    alu.en && alu.upd_carry |=> cpu_flags[0] == $past(alu.carry);
  endproperty
  a_carry: assert property (p_carry) else $error("carry not captured");
  property p_zero;
    alu.en && alu.upd_zero && alu.size == crf_pkg::SIZE_WORD
      |=> cpu_flags[2] == ($past(alu.result[15:0]) == 16'h0000);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_sign;
    alu.en && alu.upd_sign && alu.size == crf_pkg::SIZE_BYTE |=> cpu_flags[3] == $past(alu.result[7]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");
  property p_ovf;
    alu.en && alu.upd_ovf |=> cpu_flags[5] == $past(alu.ovf);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
  property p_pc_step;
    pc_step_en && !pc_load
      |=> next_instr_ptr == $past(next_instr_ptr) + $past(pc_step_len);
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step wrong");
endmodule

bind crf_core_regs crf_core_regs_chk u_chk (.core_clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .ex_wr, .alu, .pc_step_en, .pc_step_len, .cpu_flags,
  .next_instr_ptr);

// file: testbench/crf_exec_model.sv
// execution unit and alu model on the operand side
`timescale 1ns/10ps
module crf_exec_model (
  input wire logic core_clk,
  input wire logic [31:0] rd_data [2],
  output crf_pkg::crf_reg_id_t rd_id [2],
  output crf_pkg::crf_wr_t ex_wr,
  output crf_pkg::crf_alu_t alu,
  output logic pc_step_en,
  output logic [2:0] pc_step_len
);
  initial
  begin
    rd_id[0] = crf_pkg::ID_DATA_ZERO;
    rd_id[1] = crf_pkg::ID_DATA_ONE;
    ex_wr = '0;
    alu = '0;
    pc_step_en = 1'b0;
    pc_step_len = 3'h0;
  end
  // ==========
  // one-cycle write, alu and step requests; rd sets the read selector and leaves it set
  task automatic wr(input crf_pkg::crf_reg_id_t i, input logic [31:0] d);
    @(posedge core_clk);
    ex_wr <= '{en: 1'b1, id: i, data: d};
    @(posedge core_clk);
    ex_wr.en <= 1'b0;
  endtask
  task automatic rd(input crf_pkg::crf_reg_id_t i, output logic [31:0] d);
    @(posedge core_clk);
    rd_id[0] <= i;
    repeat (2) @(posedge core_clk);
    d = rd_data[0];
  endtask
  task automatic op(input crf_pkg::crf_size_t s, input logic [31:0] r, input logic c, o);
    @(posedge core_clk);
    alu <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, s, r, c, o};
    @(posedge core_clk);
    alu.en <= 1'b0;
  endtask
  task automatic step(input logic [2:0] n);
    @(posedge core_clk);
    pc_step_en <= 1'b1;
    pc_step_len <= n;
    @(posedge core_clk);
    pc_step_en <= 1'b0;
  endtask
endmodule

// file: testbench/tb.sv
// self-checking bench for the register file
`timescale 1ns/10ps
module tb;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, pc_step_en, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [31:0] rd_data [2];
  crf_pkg::crf_reg_id_t rd_id [2];
  crf_pkg::crf_wr_t ex_wr;
  crf_pkg::crf_alu_t alu;
  logic [2:0] pc_step_len;
  logic [10:0] cpu_flags;
  logic [19:0] next_instr_ptr;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  crf_core_regs uut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rd_id, .rd_data, .ex_wr, .alu, .pc_step_en, .pc_step_len, .cpu_flags,
    .next_instr_ptr);
  crf_exec_model ex (.core_clk, .rd_data, .rd_id, .ex_wr, .alu, .pc_step_en, .pc_step_len);
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      end_sim();
    end
  end
  // ==========
  // tasks
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x)
    begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(v, x);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // tests
  initial
  begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i <= 20; i++)
      rdc(12'(i * 4), 32'h0);
    apb(1'b1, 12'h000, 32'hFFFF1234);
    apb(1'b1, 12'h008, 32'h0000ABCD);
    rdc(12'h000, 32'h00001234);
    rdc(12'h020, 32'hABCD1234);
    apb(1'b1, 12'h014, 32'h0000005A);
    rdc(12'h000, 32'h00005A34);
    rdc(12'h010, 32'h00000034);
    apb(1'b1, 12'h024, 32'h87654321);
    rdc(12'h00C, 32'h00008765);
    rdc(12'h01C, 32'h00000043);
    apb(1'b1, 12'h030, 32'hCAFE0BAD);
    apb(1'b1, 12'h028, 32'h00001111);
    rdc(12'h030, 32'hCAFE1111);
    for (int i = 13; i <= 18; i++)
      apb(1'b1, 12'(i * 4), 32'hFFFFFFFF);
    rdc(12'h034, 32'h0000FFFF);
    rdc(12'h038, 32'h0000FFFF);
    rdc(12'h048, 32'h000FFFFF);
    apb(1'b1, 12'h050, 32'hFFFFFFFD);
    rdc(12'h050, 32'h000007FD);
    $display("test registers done");
    apb(1'b1, 12'h080, 32'h00002222);
    apb(1'b1, 12'h03C, 32'h0000AAAA);
    apb(1'b1, 12'h050, 32'h00000000);
    rdc(12'h044, 32'h0000FFFF);
    ex.rd(crf_pkg::ID_DATA_ZERO, v);
    check(v, 32'h00005A34);
    apb(1'b1, 12'h050, 32'h00000090);
    rdc(12'h044, 32'h0000AAAA);
    ex.rd(crf_pkg::ID_DATA_ZERO, v);
    check(v, 32'h00002222);
    apb(1'b1, 12'h050, 32'h00000000);
    ex.wr(crf_pkg::ID_D0_LOWER, 32'h000000EE);
    ex.rd(crf_pkg::ID_DATA_ZERO, v);
    check(v, 32'h00005AEE);
    ex.wr(crf_pkg::ID_WIDE_ADDR, 32'h12345678);
    ex.rd(crf_pkg::ID_ADDR_ONE, v);
    check(v, 32'h00001234);
    $display("test bank and stack done");
    apb(1'b1, 12'h0B8, 32'h00000000);
    check({31'h0, e}, 32'h1);
    rdc(12'h038, 32'h0000FFFF);
    apb(1'b0, 12'h101, 32'h0);
    check({31'h0, e}, 32'h1);
    ex.op(crf_pkg::SIZE_BYTE, 32'hFFFFFF80, 1'b1, 1'b0);
    rdc(12'h050, 32'h00000009);
    ex.op(crf_pkg::SIZE_WORD, 32'hFFFF0000, 1'b0, 1'b1);
    rdc(12'h050, 32'h00000024);
    ex.op(crf_pkg::SIZE_LONG, 32'h00000000, 1'b1, 1'b1);
    rdc(12'h050, 32'h00000025);
    apb(1'b1, 12'h04C, 32'h000FFFFE);
    ex.step(3'h3);
    rdc(12'h04C, 32'h00000001);
    check({12'h000, next_instr_ptr}, 32'h00000001);
    check({21'h000000, cpu_flags}, 32'h00000025);
    check(rd_data[1], 32'h00004321);
    $display("test alu and pc done");
    end_sim();
  end
endmodule

// file: verilog/crf_core_regs.sv
// programmer-visible register set of the cpu core with apb access
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "crf_defines.svh"

// Summary of operation
// - four 16-bit data registers, read and written as operands
// - first two data registers also addressable as separate upper and lower bytes
// - pairs two-zero and three-one form 32-bit operands, higher register on top
// - two 16-bit address registers usable as pointers and operands
// - address registers pair to 32 bits with register one on top
// - 16-bit frame base register
// - 20-bit vector table base register
// - 20-bit program counter holding next instruction address
// - separate 16-bit user and interrupt stack pointers
// - stack-select flag picks the active stack pointer
// - 16-bit static base register
// - flag register is 11 bits wide
// - carry flag takes alu carry, borrow or shifted-out bit
// - zero flag set when result is zero, else cleared
// - sign flag set when result is negative, else cleared
// - bank flag selects bank for data, address and frame base
// - overflow flag set on signed overflow, else cleared
module crf_core_regs (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CRF_APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input crf_pkg::crf_reg_id_t rd_id [2],
  output logic [31:0] rd_data [2],
  input crf_pkg::crf_wr_t ex_wr,
  input crf_pkg::crf_alu_t alu,
  input wire logic pc_step_en,
  input wire logic [2:0] pc_step_len,
  output logic [`CRF_FLAG_W-1:0] cpu_flags,
  output logic [`CRF_LONG_W-1:0] next_instr_ptr
);

  // ============================================================
  // storage
  logic [15:0] data_q [`CRF_NUM_BANKS][`CRF_NUM_DATA];
  logic [15:0] addr_q [`CRF_NUM_BANKS][2];
  logic [15:0] frame_base_q [`CRF_NUM_BANKS];
  logic [15:0] static_base_q;
  logic [15:0] user_stack_ptr_q;
  logic [15:0] interrupt_stack_ptr_q;
  logic [19:0] vector_table_base_q;
  logic [19:0] next_instr_ptr_q;
  logic [10:0] cpu_flags_q;
  logic [10:0] cpu_flags_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rd_data_q [2];

  // write selected this cycle, with the bank it targets
  logic wr_en;
  logic wr_bank;
  crf_pkg::crf_reg_id_t wr_id;
  logic [31:0] wr_data;

  logic cur_bank;
  logic apb_hit;
  logic apb_ok;
  logic apb_bank;
  crf_pkg::crf_reg_id_t apb_id;

  assign cur_bank = cpu_flags_q[`CRF_FLG_BANK];

  // ============================================================
  // read decode, shared by operand ports and apb
  function automatic logic is_banked(input crf_pkg::crf_reg_id_t id);
    is_banked = (id <= crf_pkg::ID_WIDE_ADDR) || (id == crf_pkg::ID_FRAME_BASE);
  endfunction

  function automatic logic [31:0] read_reg(input crf_pkg::crf_reg_id_t id, input logic b);
    read_reg = 32'h00000000;
    case (id)
      crf_pkg::ID_DATA_ZERO: read_reg = {16'h0000, data_q[b][0]};
      crf_pkg::ID_DATA_ONE: read_reg = {16'h0000, data_q[b][1]};
      crf_pkg::ID_DATA_TWO: read_reg = {16'h0000, data_q[b][2]};
      crf_pkg::ID_DATA_THREE: read_reg = {16'h0000, data_q[b][3]};
      crf_pkg::ID_D0_LOWER: read_reg = {24'h000000, data_q[b][0][7:0]};
      crf_pkg::ID_D0_UPPER: read_reg = {24'h000000, data_q[b][0][15:8]};
      crf_pkg::ID_D1_LOWER: read_reg = {24'h000000, data_q[b][1][7:0]};
      crf_pkg::ID_D1_UPPER: read_reg = {24'h000000, data_q[b][1][15:8]};
      crf_pkg::ID_WIDE_LOW: read_reg = {data_q[b][2], data_q[b][0]};
      crf_pkg::ID_WIDE_HIGH: read_reg = {data_q[b][3], data_q[b][1]};
      crf_pkg::ID_ADDR_ZERO: read_reg = {16'h0000, addr_q[b][0]};
      crf_pkg::ID_ADDR_ONE: read_reg = {16'h0000, addr_q[b][1]};
      crf_pkg::ID_WIDE_ADDR: read_reg = {addr_q[b][1], addr_q[b][0]};
      crf_pkg::ID_FRAME_BASE: read_reg = {16'h0000, frame_base_q[b]};
      crf_pkg::ID_STATIC_BASE: read_reg = {16'h0000, static_base_q};
      crf_pkg::ID_USER_SP: read_reg = {16'h0000, user_stack_ptr_q};
      crf_pkg::ID_INTR_SP: read_reg = {16'h0000, interrupt_stack_ptr_q};
      crf_pkg::ID_ACTIVE_SP:
      begin
        if (cpu_flags_q[`CRF_FLG_STACK])
          read_reg = {16'h0000, user_stack_ptr_q};
        else
          read_reg = {16'h0000, interrupt_stack_ptr_q};
      end
      crf_pkg::ID_VECTOR_BASE: read_reg = {12'h000, vector_table_base_q};
      crf_pkg::ID_NEXT_INSTR: read_reg = {12'h000, next_instr_ptr_q};
      crf_pkg::ID_CPU_FLAGS: read_reg = {21'h000000, cpu_flags_q};
      default: read_reg = 32'h00000000;
    endcase
  endfunction

  // ============================================================
  // operand read ports, registered
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++)
    begin : g_rd
      always_ff @(posedge core_clk)
      begin
        if (!rst_b)
          rd_data_q[gp] <= `CRF_RST_BUS;
        else
          rd_data_q[gp] <= read_reg(rd_id[gp], cur_bank);
      end
      assign rd_data[gp] = rd_data_q[gp];
    end
  endgenerate

  // ============================================================
  // apb slave: one wait state, stalls while the execution unit writes
  assign apb_bank = paddr[`CRF_APB_BANK_BIT];
  assign apb_id = crf_pkg::crf_reg_id_t'(paddr[`CRF_APB_ID_MSB:`CRF_APB_ID_LSB]);
  assign apb_ok = (paddr[`CRF_APB_TOP_MSB:`CRF_APB_TOP_LSB] == 4'h0) &&
                  (paddr[1:0] == 2'h0) &&
                  (paddr[`CRF_APB_ID_MSB:`CRF_APB_ID_LSB] <= 5'h14) &&
                  (!apb_bank || is_banked(apb_id));
  assign apb_hit = psel && penable && !pready_q && !ex_wr.en;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `CRF_RST_BUS;
    end
    else
    begin
      pready_q <= apb_hit;
      if (apb_hit)
      begin
        pslverr_q <= !apb_ok;
        prdata_q <= (apb_ok && !pwrite) ? read_reg(apb_id, apb_bank) : `CRF_RST_BUS;
      end
      else
      begin
        pslverr_q <= 1'b0;
        prdata_q <= `CRF_RST_BUS;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ============================================================
  // write arbitration: execution unit first, apb otherwise
  always_comb
  begin
    wr_en = 1'b0;
    wr_bank = cur_bank;
    wr_id = ex_wr.id;
    wr_data = ex_wr.data;
    if (ex_wr.en)
      wr_en = 1'b1;
    else if (apb_hit && apb_ok && pwrite)
    begin
      wr_en = 1'b1;
      wr_bank = apb_bank;
      wr_id = apb_id;
      wr_data = pwdata;
    end
  end

  // ============================================================
  // banked data registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      for (int b = 0; b < `CRF_NUM_BANKS; b++)
        for (int i = 0; i < `CRF_NUM_DATA; i++)
          data_q[b][i] <= `CRF_RST_WORD;
    end
    else if (wr_en)
    begin
      case (wr_id)
        crf_pkg::ID_DATA_ZERO: data_q[wr_bank][0] <= wr_data[15:0];
        crf_pkg::ID_DATA_ONE: data_q[wr_bank][1] <= wr_data[15:0];
        crf_pkg::ID_DATA_TWO: data_q[wr_bank][2] <= wr_data[15:0];
        crf_pkg::ID_DATA_THREE: data_q[wr_bank][3] <= wr_data[15:0];
        crf_pkg::ID_D0_LOWER: data_q[wr_bank][0][7:0] <= wr_data[7:0];
        crf_pkg::ID_D0_UPPER: data_q[wr_bank][0][15:8] <= wr_data[7:0];
        crf_pkg::ID_D1_LOWER: data_q[wr_bank][1][7:0] <= wr_data[7:0];
        crf_pkg::ID_D1_UPPER: data_q[wr_bank][1][15:8] <= wr_data[7:0];
        crf_pkg::ID_WIDE_LOW:
        begin
          data_q[wr_bank][0] <= wr_data[15:0];
          data_q[wr_bank][2] <= wr_data[31:16];
        end
        crf_pkg::ID_WIDE_HIGH:
        begin
          data_q[wr_bank][1] <= wr_data[15:0];
          data_q[wr_bank][3] <= wr_data[31:16];
        end
        default:
        begin
        end
      endcase
    end
  end

  // ============================================================
  // banked address and frame base registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      for (int b = 0; b < `CRF_NUM_BANKS; b++)
      begin
        addr_q[b][0] <= `CRF_RST_WORD;
        addr_q[b][1] <= `CRF_RST_WORD;
        frame_base_q[b] <= `CRF_RST_WORD;
      end
    end
    else if (wr_en)
    begin
      case (wr_id)
        crf_pkg::ID_ADDR_ZERO: addr_q[wr_bank][0] <= wr_data[15:0];
        crf_pkg::ID_ADDR_ONE: addr_q[wr_bank][1] <= wr_data[15:0];
        crf_pkg::ID_WIDE_ADDR:
        begin
          addr_q[wr_bank][0] <= wr_data[15:0];
          addr_q[wr_bank][1] <= wr_data[31:16];
        end
        crf_pkg::ID_FRAME_BASE: frame_base_q[wr_bank] <= wr_data[15:0];
        default:
        begin
        end
      endcase
    end
  end

  // ============================================================
  // static base, stack pointers, vector table base
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      static_base_q <= `CRF_RST_WORD;
      user_stack_ptr_q <= `CRF_RST_WORD;
      interrupt_stack_ptr_q <= `CRF_RST_WORD;
      vector_table_base_q <= `CRF_RST_LONG;
    end
    else if (wr_en)
    begin
      case (wr_id)
        crf_pkg::ID_STATIC_BASE: static_base_q <= wr_data[15:0];
        crf_pkg::ID_USER_SP: user_stack_ptr_q <= wr_data[15:0];
        crf_pkg::ID_INTR_SP: interrupt_stack_ptr_q <= wr_data[15:0];
        crf_pkg::ID_ACTIVE_SP:
        begin
          if (cpu_flags_q[`CRF_FLG_STACK])
            user_stack_ptr_q <= wr_data[15:0];
          else
            interrupt_stack_ptr_q <= wr_data[15:0];
        end
        crf_pkg::ID_VECTOR_BASE: vector_table_base_q <= wr_data[19:0];
        default:
        begin
        end
      endcase
    end
  end

  // ============================================================
  // program counter: a load wins over the step
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      next_instr_ptr_q <= `CRF_RST_LONG;
    else if (wr_en && wr_id == crf_pkg::ID_NEXT_INSTR)
      next_instr_ptr_q <= wr_data[19:0];
    else if (pc_step_en)
      next_instr_ptr_q <= next_instr_ptr_q + {17'h00000, pc_step_len};
  end

  assign next_instr_ptr = next_instr_ptr_q;

  // ============================================================
  // flags: whole write first, alu status bits on top
  always_comb
  begin
    cpu_flags_d = cpu_flags_q;
    if (wr_en && wr_id == crf_pkg::ID_CPU_FLAGS)
      cpu_flags_d = wr_data[10:0];
    if (alu.en)
    begin
      if (alu.upd_carry)
        cpu_flags_d[`CRF_FLG_CARRY] = alu.carry;
      if (alu.upd_ovf)
        cpu_flags_d[`CRF_FLG_OVF] = alu.ovf;
      if (alu.upd_zero)
      begin
        case (alu.size)
          crf_pkg::SIZE_BYTE: cpu_flags_d[`CRF_FLG_ZERO] = (alu.result[7:0] == 8'h00);
          crf_pkg::SIZE_WORD: cpu_flags_d[`CRF_FLG_ZERO] = (alu.result[15:0] == 16'h0000);
          default: cpu_flags_d[`CRF_FLG_ZERO] = (alu.result == 32'h00000000);
        endcase
      end
      if (alu.upd_sign)
      begin
        case (alu.size)
          crf_pkg::SIZE_BYTE: cpu_flags_d[`CRF_FLG_SIGN] = alu.result[7];
          crf_pkg::SIZE_WORD: cpu_flags_d[`CRF_FLG_SIGN] = alu.result[15];
          default: cpu_flags_d[`CRF_FLG_SIGN] = alu.result[31];
        endcase
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      cpu_flags_q <= `CRF_RST_FLAGS;
    else
      cpu_flags_q <= cpu_flags_d;
  end

  assign cpu_flags = cpu_flags_q;

endmodule

// file: verilog/crf_defines.svh
// constants for the cpu core register file: offsets, field positions, reset values
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH

// ============================================================
// apb map: byte address = {bank, register id} * 4
`define CRF_APB_ADDR_W 12
`define CRF_APB_BANK_BIT 7
`define CRF_APB_ID_MSB 6
`define CRF_APB_ID_LSB 2
`define CRF_APB_BANK1_BASE 12'h080
`define CRF_APB_TOP_MSB 11
`define CRF_APB_TOP_LSB 8

// ============================================================
// widths
`define CRF_WORD_W 16
`define CRF_LONG_W 20
`define CRF_FLAG_W 11
`define CRF_NUM_BANKS 2
`define CRF_NUM_DATA 4

// ============================================================
// flag bit positions
`define CRF_FLG_CARRY 0
`define CRF_FLG_DEBUG 1
`define CRF_FLG_ZERO 2
`define CRF_FLG_SIGN 3
`define CRF_FLG_BANK 4
`define CRF_FLG_OVF 5
`define CRF_FLG_INTEN 6
`define CRF_FLG_STACK 7
`define CRF_FLG_IPL_MSB 10
`define CRF_FLG_IPL_LSB 8

// ============================================================
// reset values
`define CRF_RST_WORD 16'h0000
`define CRF_RST_LONG 20'h00000
`define CRF_RST_FLAGS 11'h000
`define CRF_RST_BUS 32'h00000000

`endif

// file: verilog/crf_pkg.sv
// types shared by the cpu core register file
package crf_pkg;

  // ============================================================
  // register selectors for operand, write and apb access
  typedef enum logic [4:0] {
    ID_DATA_ZERO = 5'h00,
    ID_DATA_ONE = 5'h01,
    ID_DATA_TWO = 5'h02,
    ID_DATA_THREE = 5'h03,
    ID_D0_LOWER = 5'h04,
    ID_D0_UPPER = 5'h05,
    ID_D1_LOWER = 5'h06,
    ID_D1_UPPER = 5'h07,
    ID_WIDE_LOW = 5'h08,
    ID_WIDE_HIGH = 5'h09,
    ID_ADDR_ZERO = 5'h0A,
    ID_ADDR_ONE = 5'h0B,
    ID_WIDE_ADDR = 5'h0C,
    ID_FRAME_BASE = 5'h0D,
    ID_STATIC_BASE = 5'h0E,
    ID_USER_SP = 5'h0F,
    ID_INTR_SP = 5'h10,
    ID_ACTIVE_SP = 5'h11,
    ID_VECTOR_BASE = 5'h12,
    ID_NEXT_INSTR = 5'h13,
    ID_CPU_FLAGS = 5'h14
  } crf_reg_id_t;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } crf_size_t;

  // write request from the execution unit
  typedef struct packed {
    logic en;
    crf_reg_id_t id;
    logic [31:0] data;
  } crf_wr_t;

  // status update from the alu
  typedef struct packed {
    logic en;
    logic upd_carry;
    logic upd_zero;
    logic upd_sign;
    logic upd_ovf;
    crf_size_t size;
    logic [31:0] result;
    logic carry;
    logic ovf;
  } crf_alu_t;

endpackage
